// ===== design/autosave_ctrl_consts.vh
// constants for the autosave mode sequence controller
`ifndef AUTOSAVE_CTRL_CONSTS_VH
`define AUTOSAVE_CTRL_CONSTS_VH
`define SEQ_ADDR_0 17'h04e38
`define SEQ_ADDR_1 17'h0b1c7
`define SEQ_ADDR_2 17'h083e0
`define SEQ_ADDR_3 17'h07c1f
`define SEQ_ADDR_4 17'h0703f
`define SEQ_ADDR_OFF 17'h08b45
`define SEQ_ADDR_ON 17'h04b46
`define SEQ_ADDR_STORE 17'h08fc0
`define ADDR_W 17
`define DATA_W 8
`define CLK_PERIOD_NS 4
`define T_SETUP_NS 10
`define T_STROBE_NS 45
`define T_RECOVER_NS 20
`define T_SETUP_CYC ((`T_SETUP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_STROBE_CYC ((`T_STROBE_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define T_RECOVER_CYC ((`T_RECOVER_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`endif

// ===== design/sram_read_cycle.v
// one chip-select framed sram read or write cycle with fixed timing
`timescale 1ns/1ps
`include "autosave_ctrl_consts.vh"
module sram_read_cycle #(
    parameter AW = `ADDR_W,
    parameter DW = `DATA_W,
    parameter [7:0] SETUP_CYC = `T_SETUP_CYC,
    parameter [7:0] STROBE_CYC = `T_STROBE_CYC,
    parameter [7:0] RECOVER_CYC = `T_RECOVER_CYC
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire start_i,
    input wire wr_i,
    input wire [AW-1:0] addr_i,
    input wire [DW-1:0] wdata_i,
    input wire [DW-1:0] dq_i,
    output reg busy_o,
    output reg done_o,
    output reg [DW-1:0] rdata_o,
    output reg ce_n_o,
    output reg oe_n_o,
    output reg we_n_o,
    output reg [AW-1:0] addr_o,
    output reg [DW-1:0] dq_o,
    output reg dq_oe_o
);
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_SETUP = 2'd1;
    localparam [1:0] S_STROBE = 2'd2;
    localparam [1:0] S_REC = 2'd3;
    reg [1:0] state_q;
    reg [7:0] cnt_q;
    reg wr_q;
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            state_q <= S_IDLE;
            cnt_q <= 8'h00;
            wr_q <= 1'b0;
            busy_o <= 1'b0;
            done_o <= 1'b0;
            rdata_o <= {DW{1'b0}};
            ce_n_o <= 1'b1;
            oe_n_o <= 1'b1;
            we_n_o <= 1'b1;
            addr_o <= {AW{1'b0}};
            dq_o <= {DW{1'b0}};
            dq_oe_o <= 1'b0;
        end
        else
        begin
            done_o <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    if (start_i)
                    begin
                        // address settles before chip select falls
                        addr_o <= addr_i;
                        wr_q <= wr_i;
                        dq_o <= wdata_i;
                        dq_oe_o <= wr_i;
                        busy_o <= 1'b1;
                        cnt_q <= SETUP_CYC;
                        state_q <= S_SETUP;
                    end
                end
                S_SETUP:
                begin
                    if (cnt_q <= 8'h01)
                    begin
                        ce_n_o <= 1'b0;
                        oe_n_o <= wr_q;
                        we_n_o <= ~wr_q;
                        cnt_q <= STROBE_CYC;
                        state_q <= S_STROBE;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                S_STROBE:
                begin
                    if (cnt_q <= 8'h01)
                    begin
                        rdata_o <= dq_i;
                        ce_n_o <= 1'b1;
                        oe_n_o <= 1'b1;
                        we_n_o <= 1'b1;
                        cnt_q <= RECOVER_CYC;
                        state_q <= S_REC;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                S_REC:
                begin
                    dq_oe_o <= 1'b0;
                    if (cnt_q <= 8'h01)
                    begin
                        busy_o <= 1'b0;
                        done_o <= 1'b1;
                        state_q <= S_IDLE;
                    end
                    else
                        cnt_q <= cnt_q - 8'h01;
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end
endmodule

// ===== design/autosave_mode_sequence_control.v
// host controller issuing autosave on/off read sequences and plain accesses
`timescale 1ns/1ps
`include "autosave_ctrl_consts.vh"
module autosave_mode_sequence_control #(
    parameter AW = `ADDR_W,
    parameter DW = `DATA_W
) (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire mode_req_i,
    input wire mode_on_i,
    input wire acc_req_i,
    input wire acc_wr_i,
    input wire [AW-1:0] acc_addr_i,
    input wire [DW-1:0] acc_wdata_i,
    input wire hw_save_busy_n_i,
    input wire [DW-1:0] dq_i,
    output reg busy_o,
    output reg mode_done_o,
    output reg acc_done_o,
    output reg [DW-1:0] acc_rdata_o,
    output wire ce_n_o,
    output wire oe_n_o,
    output wire we_n_o,
    output wire [AW-1:0] addr_o,
    output wire [DW-1:0] dq_o,
    output wire dq_oe_o
);
    localparam [1:0] S_IDLE = 2'd0;
    localparam [1:0] S_SEQ = 2'd1;
    localparam [1:0] S_ACC = 2'd2;
    reg [1:0] state_q;
    reg [3:0] step_q;
    reg on_q;
    reg issued_q;
    reg rst_s1_q;
    reg rst_s2_q;
    reg cyc_start;
    reg cyc_wr;
    reg [AW-1:0] cyc_addr;
    reg [AW-1:0] seq_addr;
    wire cyc_busy;
    wire cyc_done;
    wire [DW-1:0] cyc_rdata;
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            rst_s1_q <= 1'b0;
            rst_s2_q <= 1'b0;
        end
        else
        begin
            rst_s1_q <= 1'b1;
            rst_s2_q <= rst_s1_q;
        end
    end
    // steps 0-4 prefix, 5 mode address, 6-11 save sequence
    always @*
    begin
        case (step_q)
            4'd0: seq_addr = `SEQ_ADDR_0;
            4'd1: seq_addr = `SEQ_ADDR_1;
            4'd2: seq_addr = `SEQ_ADDR_2;
            4'd3: seq_addr = `SEQ_ADDR_3;
            4'd4: seq_addr = `SEQ_ADDR_4;
            4'd5: seq_addr = on_q ? `SEQ_ADDR_ON : `SEQ_ADDR_OFF;
            4'd6: seq_addr = `SEQ_ADDR_0;
            4'd7: seq_addr = `SEQ_ADDR_1;
            4'd8: seq_addr = `SEQ_ADDR_2;
            4'd9: seq_addr = `SEQ_ADDR_3;
            4'd10: seq_addr = `SEQ_ADDR_4;
            4'd11: seq_addr = `SEQ_ADDR_STORE;
            default: seq_addr = `SEQ_ADDR_0;
        endcase
    end
    always @*
    begin
        cyc_start = 1'b0;
        cyc_wr = 1'b0;
        cyc_addr = seq_addr;
        // no cycle opens while the device holds its busy pin low
        if (state_q == S_SEQ && !issued_q && !cyc_busy && hw_save_busy_n_i)
            cyc_start = 1'b1;
        if (state_q == S_ACC && !issued_q && !cyc_busy && hw_save_busy_n_i)
        begin
            cyc_start = 1'b1;
            cyc_wr = acc_wr_i;
            cyc_addr = acc_addr_i;
        end
    end
    always @(posedge sys_clk_i or negedge rst_s2_q)
    begin
        if (!rst_s2_q)
        begin
            state_q <= S_IDLE;
            step_q <= 4'd0;
            on_q <= 1'b1;
            issued_q <= 1'b0;
            busy_o <= 1'b0;
            mode_done_o <= 1'b0;
            acc_done_o <= 1'b0;
            acc_rdata_o <= {DW{1'b0}};
        end
        else
        begin
            mode_done_o <= 1'b0;
            acc_done_o <= 1'b0;
            case (state_q)
                S_IDLE:
                begin
                    // mode wins; no access can interleave a sequence
                    if (mode_req_i)
                    begin
                        on_q <= mode_on_i;
                        step_q <= 4'd0;
                        issued_q <= 1'b0;
                        busy_o <= 1'b1;
                        state_q <= S_SEQ;
                    end
                    else if (acc_req_i)
                    begin
                        issued_q <= 1'b0;
                        busy_o <= 1'b1;
                        state_q <= S_ACC;
                    end
                end
                S_SEQ:
                begin
                    if (cyc_start)
                        issued_q <= 1'b1;
                    if (cyc_done)
                    begin
                        issued_q <= 1'b0;
                        if (step_q == 4'd11)
                        begin
                            busy_o <= 1'b0;
                            mode_done_o <= 1'b1;
                            state_q <= S_IDLE;
                        end
                        else
                            step_q <= step_q + 4'd1;
                    end
                end
                S_ACC:
                begin
                    if (cyc_start)
                        issued_q <= 1'b1;
                    if (cyc_done)
                    begin
                        acc_rdata_o <= cyc_rdata;
                        acc_done_o <= 1'b1;
                        busy_o <= 1'b0;
                        state_q <= S_IDLE;
                    end
                end
                default:
                    state_q <= S_IDLE;
            endcase
        end
    end
    sram_read_cycle #(
        .AW(AW),
        .DW(DW)
    ) u_cycle (
        .sys_clk_i(sys_clk_i),
        .rst_b_i(rst_s2_q),
        .start_i(cyc_start),
        .wr_i(cyc_wr),
        .addr_i(cyc_addr),
        .wdata_i(acc_wdata_i),
        .dq_i(dq_i),
        .busy_o(cyc_busy),
        .done_o(cyc_done),
        .rdata_o(cyc_rdata),
        .ce_n_o(ce_n_o),
        .oe_n_o(oe_n_o),
        .we_n_o(we_n_o),
        .addr_o(addr_o),
        .dq_o(dq_o),
        .dq_oe_o(dq_oe_o)
    );
endmodule

// ===== test/autosave_chk_asserts.sv
// port checker for the autosave sequence controller
`timescale 1ns/1ps
`include "autosave_ctrl_consts.vh"
module autosave_chk (
    input wire sys_clk_i,
    input wire rst_b_i,
    input wire mode_req_i,
    input wire busy_o,
    input wire mode_done_o,
    input wire acc_done_o,
    input wire ce_n_o,
    input wire oe_n_o,
    input wire we_n_o,
    input wire [16:0] addr_o,
    input wire dq_oe_o
);
    reg in_mode_q;
    reg [3:0] n_q;
    default clocking @(posedge sys_clk_i); endclocking
    default disable iff (!rst_b_i);
    // n_q counts device cycles opened inside one mode request
    always @(posedge sys_clk_i or negedge rst_b_i)
    begin
        if (!rst_b_i)
        begin
            in_mode_q <= 1'b0;
            n_q <= 4'h0;
        end
        else if (mode_req_i && !busy_o && !in_mode_q)
        begin
            in_mode_q <= 1'b1;
            n_q <= 4'h0;
        end
        else if (mode_done_o)
            in_mode_q <= 1'b0;
        else if (in_mode_q && $fell(ce_n_o))
            n_q <= n_q + 4'h1;
    end
    rd_not_wr_a: assert property (!oe_n_o |-> we_n_o)
        else $error("read and write strobes low together");
    seq_no_wr_a: assert property (in_mode_q |-> we_n_o && !dq_oe_o)
        else $error("write strobe low inside mode sequence");
    wr_drive_a: assert property (!we_n_o |-> dq_oe_o && !ce_n_o)
        else $error("write without data drive or select");
    idle_quiet_a: assert property (!busy_o |-> ce_n_o && we_n_o)
        else $error("strobe active while idle");
    seq_start_a: assert property ($fell(ce_n_o) && in_mode_q && n_q == 4'h0
        |-> addr_o == `SEQ_ADDR_0)
        else $error("sequence does not open at first prefix address");
    seq_save_a: assert property ($fell(ce_n_o) && in_mode_q && n_q == 4'hb
        |-> addr_o == `SEQ_ADDR_STORE)
        else $error("mode change not followed by save");
    mode_count_a: assert property (mode_done_o |-> n_q == 4'hc ##1 !mode_done_o)
        else $error("mode done without twelve reads");
    addr_hold_a: assert property (!ce_n_o && $past(!ce_n_o) |-> $stable(addr_o))
        else $error("address moved during a cycle");
    acc_out_a: assert property (acc_done_o |-> !in_mode_q ##1 !acc_done_o)
        else $error("access completed inside a mode sequence");
    mode_c: cover property (mode_done_o);
    acc_c: cover property (acc_done_o);
    wr_c: cover property (!we_n_o);
endmodule
bind autosave_mode_sequence_control autosave_chk u_chk (.sys_clk_i(sys_clk_i),
    .rst_b_i(rst_b_i), .mode_req_i(mode_req_i), .busy_o(busy_o),
    .mode_done_o(mode_done_o), .acc_done_o(acc_done_o), .ce_n_o(ce_n_o),
    .oe_n_o(oe_n_o), .we_n_o(we_n_o), .addr_o(addr_o), .dq_oe_o(dq_oe_o));

// ===== test/nvsram_model.sv
// behavioural nonvolatile sram with mode sequence detection
`timescale 1ns/1ps
`include "autosave_ctrl_consts.vh"
module nvsram_model (
    input wire clk_i,
    input wire ce_n_i,
    input wire oe_n_i,
    input wire we_n_i,
    input wire [16:0] addr_i,
    input wire [7:0] dq_i,
    output wire [7:0] dq_o,
    output wire hw_save_busy_n_o,
    output reg autosave_on_o,
    output reg [7:0] saves_o
);
    reg [7:0] mem [0:255];
    reg [7:0] last_q, dq_q;
    reg [16:0] addr_q;
    reg ce_q, we_q;
    reg [2:0] stp;
    reg [7:0] bcnt;
    integer i;
    wire [16:0] nxt = stp == 3'h0 ? `SEQ_ADDR_0 : stp == 3'h1 ? `SEQ_ADDR_1 :
        stp == 3'h2 ? `SEQ_ADDR_2 : stp == 3'h3 ? `SEQ_ADDR_3 : `SEQ_ADDR_4;
    wire [16:0] a0 = `SEQ_ADDR_0, aof = `SEQ_ADDR_OFF, aon = `SEQ_ADDR_ON;
    wire [16:0] ast = `SEQ_ADDR_STORE;
    // released bus shows inverted last value, never a stale copy
    assign dq_o = (!ce_n_i && !oe_n_i) ? mem[addr_i[7:0]] : ~last_q;
    assign hw_save_busy_n_o = bcnt == 8'h00;
    initial
    begin
        autosave_on_o = 1'b1;
        for (i = 0; i < 256; i = i + 1)
            mem[i] = 8'h00;
        {stp, bcnt, saves_o, last_q, ce_q} = 28'h0000001;
    end
    always @(posedge clk_i)
    begin
        ce_q <= ce_n_i;
        if (bcnt != 8'h00)
            bcnt <= bcnt - 8'h01;
        if (!ce_n_i)
        begin
            we_q <= we_n_i;
            addr_q <= addr_i;
            dq_q <= dq_i;
        end
        else if (!ce_q)
        begin
            last_q <= mem[addr_q[7:0]];
            if (!we_q)
            begin
                // writes while busy are inhibited
                if (hw_save_busy_n_o)
                    mem[addr_q[7:0]] <= dq_q;
                stp <= 3'h0;
            end
            else if (stp == 3'h5)
            begin
                stp <= 3'h0;
                if (addr_q[14:2] == aof[14:2])
                    autosave_on_o <= 1'b0;
                if (addr_q[14:2] == aon[14:2])
                    autosave_on_o <= 1'b1;
                if (addr_q[14:2] == ast[14:2])
                begin
                    saves_o <= saves_o + 8'h01;
                    bcnt <= 8'h32;
                end
            end
            else if (addr_q[14:2] == nxt[14:2])
                stp <= stp + 3'h1;
            else
                stp <= {2'b00, addr_q[14:2] == a0[14:2]};
        end
    end
endmodule

// ===== test/tb_top.sv
// self-checking bench for the autosave sequence controller
`timescale 1ns/1ps
`include "autosave_ctrl_consts.vh"
module tb_top;
    reg sys_clk_i = 1'b0, rst_b_i = 1'b0, mode_req = 1'b0, mode_on = 1'b0;
    reg acc_req = 1'b0, acc_wr = 1'b0;
    reg [16:0] acc_addr = 17'h00000;
    reg [7:0] acc_wdata = 8'h00, rd, s;
    wire busy, mdone, adone, ce_n, oe_n, we_n, dq_oe, hsb_n, on;
    wire [7:0] rdata, dq_o, dq_i, saves;
    wire [16:0] addr;
    integer err_count = 0, checked = 0;
    always #2 sys_clk_i = ~sys_clk_i;
    autosave_mode_sequence_control u_dut (.sys_clk_i(sys_clk_i), .rst_b_i(rst_b_i),
        .mode_req_i(mode_req), .mode_on_i(mode_on), .acc_req_i(acc_req),
        .acc_wr_i(acc_wr), .acc_addr_i(acc_addr), .acc_wdata_i(acc_wdata),
        .hw_save_busy_n_i(hsb_n), .dq_i(dq_i), .busy_o(busy), .mode_done_o(mdone),
        .acc_done_o(adone), .acc_rdata_o(rdata), .ce_n_o(ce_n), .oe_n_o(oe_n),
        .we_n_o(we_n), .addr_o(addr), .dq_o(dq_o), .dq_oe_o(dq_oe));
    nvsram_model u_mem (.clk_i(sys_clk_i), .ce_n_i(ce_n), .oe_n_i(oe_n), .we_n_i(we_n),
        .addr_i(addr), .dq_i(dq_o), .dq_o(dq_i), .hw_save_busy_n_o(hsb_n),
        .autosave_on_o(on), .saves_o(saves));
    task stop_test;
    begin
        $display("checks %0d mismatches %0d", checked, err_count);
        if (err_count == 0 && checked > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    end
    endtask
    task chk(input string nm, input [16:0] exp, input [16:0] got);
    begin
        checked = checked + 1;
        if (got !== exp)
        begin
            $display("wrong value %s expected %h seen %h", nm, exp, got);
            err_count = err_count + 1;
        end
    end
    endtask
    task tick;
    begin
        @(posedge sys_clk_i);
        #1;
    end
    endtask
    // one request, raised for a single cycle, then waited on until its done pulse or a bounded wait runs out
    task req(input m, input w, input [16:0] a, input [7:0] d);
        integer n;
    begin
        tick;
        {mode_on, acc_wr, acc_addr, acc_wdata} = {w, w, a, d};
        if (m)
            mode_req = 1'b1;
        else
            acc_req = 1'b1;
        tick;
        {mode_req, acc_req} = 2'b00;
        n = 0;
        while ((m ? mdone : adone) !== 1'b1 && n < 2000)
        begin
            tick;
            n = n + 1;
        end
        chk("done", 1'b1, m ? mdone : adone);
        rd = rdata;
    end
    endtask
    task prefix(input [16:0] x);
    begin
        req(0, 0, `SEQ_ADDR_0 | x, 8'h00);
        req(0, 0, `SEQ_ADDR_1 | x, 8'h00);
        req(0, 0, `SEQ_ADDR_2 | x, 8'h00);
        req(0, 0, `SEQ_ADDR_3 | x, 8'h00);
        req(0, 0, `SEQ_ADDR_4 | x, 8'h00);
    end
    endtask
    task t_idle;
    begin
        chk("strobes", 3'b111, {ce_n, oe_n, we_n});
        chk("drive", 2'b00, {dq_oe, busy});
        chk("shipped on", 1'b1, on);
        $display("test idle done");
    end
    endtask
    task t_rw;
    begin
        req(0, 1, 17'h00012, 8'h5a);
        req(0, 0, 17'h00012, 8'h00);
        chk("read back", 8'h5a, rd);
        req(0, 0, 17'h00034, 8'h00);
        chk("blank cell", 8'h00, rd);
        $display("test access done");
    end
    endtask
    task t_mode;
    begin
        s = saves;
        req(1, 0, 17'h00000, 8'h00);
        chk("off", 1'b0, on);
        chk("saves", s + 8'h01, saves);
        req(0, 0, 17'h00012, 8'h00);
        chk("after mode", 8'h5a, rd);
        req(1, 1, 17'h00000, 8'h00);
        chk("on", 1'b1, on);
        chk("saves", s + 8'h02, saves);
        $display("test mode done");
    end
    endtask
    task t_abort;
    begin
        prefix(17'h00000);
        req(0, 1, 17'h00012, 8'h5a);
        req(0, 0, `SEQ_ADDR_OFF, 8'h00);
        chk("aborted", 1'b1, on);
        prefix(17'h10003);
        req(0, 0, `SEQ_ADDR_OFF | 17'h10003, 8'h00);
        chk("masked bits", 1'b0, on);
        req(1, 1, 17'h00000, 8'h00);
        chk("restored", 1'b1, on);
        $display("test abort done");
    end
    endtask
    initial
    begin
        #40000;
        err_count = err_count + 1;
        stop_test;
    end
    initial
    begin
        repeat (4) @(posedge sys_clk_i);
        #1 rst_b_i = 1'b1;
        repeat (3) tick;
        t_idle;
        t_rw;
        t_mode;
        t_abort;
        stop_test;
    end
endmodule
